// ### hdl/host_serial_interface_select.sv
// Strap-selected UART+I2C or SPI host front end with receive FIFO
`timescale 1ns/1ns
`include "hsi_map.svh"

// ==================================================
// Receive FIFO
module hsi_fifo #(
  parameter int W = 8,
  parameter int D = 4
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_in_valid,
  input wire logic [W-1:0] i_in_data,
  output logic o_in_ready,
  output logic o_out_valid,
  output logic [W-1:0] o_out_data,
  input wire logic i_out_ready
);
  localparam int AW = (D > 1) ? $clog2(D) : 1;
  typedef struct packed {
    logic [D-1:0][W-1:0] mem;
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
  } fifo_t;
  fifo_t f_r;
  fifo_t f_nxt;
  logic wr;
  logic rd;

  assign o_in_ready = (f_r.cnt != (AW+1)'(D));
  assign o_out_valid = (f_r.cnt != '0);
  assign o_out_data = f_r.mem[f_r.rp];

  always_comb begin
    f_nxt = f_r;
    wr = i_in_valid & o_in_ready;
    rd = o_out_valid & i_out_ready;
    if (wr) begin
      f_nxt.mem[f_r.wp] = i_in_data;
      f_nxt.wp = (f_r.wp == AW'(D - 1)) ? '0 : f_r.wp + 1'b1;
    end
    if (rd) begin
      f_nxt.rp = (f_r.rp == AW'(D - 1)) ? '0 : f_r.rp + 1'b1;
    end
    if (wr && !rd) begin
      f_nxt.cnt = f_r.cnt + 1'b1;
    end else if (rd && !wr) begin
      f_nxt.cnt = f_r.cnt - 1'b1;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      f_r <= '0;
    end else begin
      f_r <= f_nxt;
    end
  end
endmodule

// ==================================================
// Top
module host_serial_interface_select
  import hsi_pkg::*;
#(
  parameter int STRETCH_MAX = `HSI_STRETCH_CYC
) (
  input wire logic I_CLOCK,
  input wire logic I_RST,
  input wire logic I_SEL_STRAP,
  input wire logic I_LINK_SCK,
  input wire logic I_PIN_RX,
  output logic O_PIN_TX,
  output logic O_PIN_TX_OE_N,
  input wire logic I_SCL,
  output logic O_SCL,
  output logic O_SCL_OE_N,
  input wire logic I_SDA,
  output logic O_SDA,
  output logic O_SDA_OE_N,
  input wire logic I_BAUD_SET,
  input wire logic [15:0] I_BAUD_DIV,
  input wire byte_t I_TX,
  output logic O_TX_READY,
  output byte_t O_RX,
  input wire logic I_RX_READY,
  output logic O_MODE_SPI,
  output logic O_MODE_VALID,
  output logic O_RX_DROP,
  output logic O_FRAME_ERR
);
  localparam logic [22:0] TMO = 23'(STRETCH_MAX - `HSI_STRETCH_MARGIN);

  sys_t st_r;
  sys_t st_nxt;
  frame_t fr_r;
  frame_t fr_nxt;
  link_t lk_r;
  link_t lk_nxt;
  logic rst_frame;
  logic uart_en, tick, take, push, uart_push, spi_push, i2c_push, i2c_wants;
  logic [7:0] push_d;
  logic scl, sda, rise, fall, start, stop;
  logic f_ready, rx_v;
  logic [7:0] rx_d;

  // USB port lives in its own block, not on these pins
  assign O_TX_READY = take;
  assign O_RX = {rx_v, rx_d};
  assign O_MODE_SPI = st_r.spi;
  assign O_MODE_VALID = st_r.mode_ok;
  assign O_RX_DROP = st_r.drop;
  assign O_FRAME_ERR = st_r.ferr;
  assign O_SCL = 1'b0;
  assign O_SDA = 1'b0;
  assign O_SCL_OE_N = ~st_r.scl_hold;
  assign O_SDA_OE_N = ~st_r.sda_low;
  // in SPI mode, data out driven only while chip select low
  assign O_PIN_TX = st_r.spi ? fr_r.out[7] : st_r.tpin;
  assign O_PIN_TX_OE_N = ~st_r.mode_ok | (st_r.spi & I_SDA);

  hsi_fifo #(.W(`HSI_BYTE_W), .D(`HSI_FIFO_DEPTH)) u_rx_fifo (
    .i_clk(I_CLOCK),
    .i_rst(I_RST),
    .i_in_valid(push),
    .i_in_data(push_d),
    .o_in_ready(f_ready),
    .o_out_valid(rx_v),
    .o_out_data(rx_d),
    .i_out_ready(I_RX_READY)
  );

  // ==================================================
  // System clock domain
  always_comb begin
    st_nxt = st_r;
    take = 1'b0;
    uart_push = 1'b0;
    spi_push = 1'b0;
    i2c_push = 1'b0;
    st_nxt.drop = 1'b0;
    st_nxt.ferr = 1'b0;
    st_nxt.strap_s = {st_r.strap_s[0], I_SEL_STRAP};
    st_nxt.rxd_s = {st_r.rxd_s[0], I_PIN_RX};
    st_nxt.scl_s = {st_r.scl_s[1:0], I_SCL};
    st_nxt.sda_s = {st_r.sda_s[1:0], I_SDA};
    st_nxt.rxt_s = {st_r.rxt_s[1:0], lk_r.rx_tog};
    st_nxt.take_s = {st_r.take_s[1:0], lk_r.take_tog};
    // strap caught once after release, then frozen
    if (!st_r.mode_ok) begin
      st_nxt.settle = st_r.settle + 2'h1;
      if (st_r.settle == `HSI_STRAP_SETTLE) begin
        st_nxt.mode_ok = 1'b1;
        // open or high strap keeps the UART
        st_nxt.spi = ~st_r.strap_s[1];
      end
    end
    uart_en = st_r.mode_ok & ~st_r.spi;
    i2c_wants = st_r.wait_rd & st_r.scl_hold & (st_r.lead == 5'h0);
    // divisor clamped to the legal baud span
    if (I_BAUD_SET) begin
      if (I_BAUD_DIV < `HSI_DIV_MIN) begin
        st_nxt.div = `HSI_DIV_MIN;
      end else if (I_BAUD_DIV > `HSI_DIV_MAX) begin
        st_nxt.div = `HSI_DIV_MAX;
      end else begin
        st_nxt.div = I_BAUD_DIV;
      end
    end
    // one bit lasts exactly the rounded divisor
    tick = (st_r.tdiv == 16'h0);
    st_nxt.tdiv = tick ? st_r.tbaud - 16'h1 : st_r.tdiv - 16'h1;
    case (st_r.ts)
      U_IDLE: begin
        st_nxt.tdiv = st_r.tdiv;
        // no flow control input gates the transmitter
        if (uart_en && I_TX.valid && !i2c_wants) begin
          take = 1'b1;
          st_nxt.tsh = I_TX.data;
          st_nxt.tbaud = st_r.div;
          st_nxt.tdiv = st_r.div - 16'h1;
          st_nxt.ts = U_START;
          st_nxt.tpin = 1'b0;
        end
      end
      U_START: if (tick) begin
        st_nxt.ts = U_DATA;
        st_nxt.tbit = 3'h0;
        st_nxt.tpin = st_r.tsh[0];
      end
      // eight data bits, LSB first, no parity
      U_DATA: if (tick) begin
        if (st_r.tbit == 3'h7) begin
          st_nxt.ts = U_STOP;
          st_nxt.tpin = 1'b1;
        end else begin
          st_nxt.tsh = {1'b0, st_r.tsh[7:1]};
          st_nxt.tpin = st_r.tsh[1];
          st_nxt.tbit = st_r.tbit + 3'h1;
        end
      end
      U_STOP: if (tick) begin
        st_nxt.ts = U_IDLE;
      end
      default: st_nxt.ts = U_IDLE;
    endcase
    // centre sampling, re-timed at each start edge, tolerates a few percent
    st_nxt.rdiv = st_r.rdiv - 16'h1;
    case (st_r.rs)
      U_IDLE: begin
        st_nxt.rdiv = st_r.div >> 1;
        if (uart_en && !st_r.rxd_s[1]) begin
          st_nxt.rs = U_START;
        end
      end
      U_START: if (st_r.rdiv == 16'h0) begin
        st_nxt.rdiv = st_r.div - 16'h1;
        st_nxt.rbit = 3'h0;
        st_nxt.rs = st_r.rxd_s[1] ? U_IDLE : U_DATA;
      end
      U_DATA: if (st_r.rdiv == 16'h0) begin
        st_nxt.rdiv = st_r.div - 16'h1;
        st_nxt.rsh = {st_r.rxd_s[1], st_r.rsh[7:1]};
        st_nxt.rbit = st_r.rbit + 3'h1;
        if (st_r.rbit == 3'h7) begin
          st_nxt.rs = U_STOP;
        end
      end
      U_STOP: if (st_r.rdiv == 16'h0) begin
        st_nxt.rs = U_IDLE;
        uart_push = st_r.rxd_s[1];
        st_nxt.ferr = ~st_r.rxd_s[1];
      end
      default: st_nxt.rs = U_IDLE;
    endcase
    // SPI bytes only handled with the strap low
    spi_push = st_r.spi & (st_r.rxt_s[2] ^ st_r.rxt_s[1]);
    if (st_r.take_s[2] ^ st_r.take_s[1]) begin
      st_nxt.spi_full = 1'b0;
    end
    if (st_r.spi && !st_r.spi_full && I_TX.valid) begin
      take = 1'b1;
      st_nxt.spi_full = 1'b1;
      st_nxt.spi_tx = I_TX.data;
    end
    // ==================================================
    // I2C target
    scl = st_r.scl_s[1];
    sda = st_r.sda_s[1];
    rise = scl & ~st_r.scl_s[2];
    fall = ~scl & st_r.scl_s[2];
    start = scl & st_r.scl_s[2] & st_r.sda_s[2] & ~sda;
    stop = scl & st_r.scl_s[2] & ~st_r.sda_s[2] & sda;
    if (!uart_en) begin
      // I2C released whenever SPI is chosen
      st_nxt.is = I_IDLE;
      st_nxt.sda_low = 1'b0;
      st_nxt.scl_hold = 1'b0;
      st_nxt.wait_rd = 1'b0;
      st_nxt.wait_wr = 1'b0;
    end else if (st_r.scl_hold) begin
      // stretch bounded by the timeout count
      st_nxt.stc = st_r.stc + 23'h1;
      if (st_r.lead != 5'h0) begin
        st_nxt.lead = st_r.lead - 5'h1;
        st_nxt.scl_hold = (st_r.lead != 5'h1);
      end else if (st_r.wait_rd && (I_TX.valid || st_r.stc >= TMO)) begin
        // data set up, clock held a further lead time
        take = I_TX.valid;
        st_nxt.ish = I_TX.valid ? I_TX.data : `HSI_SPI_FILL;
        st_nxt.sda_low = I_TX.valid ? ~I_TX.data[7] : 1'b0;
        st_nxt.lead = `HSI_SDA_LEAD_CYC;
        st_nxt.wait_rd = 1'b0;
      end else if (st_r.wait_wr && ((f_ready && !uart_push) || st_r.stc >= TMO)) begin
        // Full FIFO past the timeout gives a NACK instead of an ACK
        i2c_push = f_ready & ~uart_push;
        st_nxt.sda_low = i2c_push;
        st_nxt.lead = `HSI_SDA_LEAD_CYC;
        st_nxt.wait_wr = 1'b0;
      end
    end else begin
      st_nxt.stc = 23'h0;
      if (start) begin
        st_nxt.is = I_ADDR;
        st_nxt.icnt = 4'h0;
        st_nxt.sda_low = 1'b0;
      end else if (stop) begin
        st_nxt.is = I_IDLE;
        st_nxt.sda_low = 1'b0;
      end else if (rise) begin
        if (st_r.is == I_ADDR || st_r.is == I_WR || st_r.is == I_RD) begin
          st_nxt.icnt = st_r.icnt + 4'h1;
        end
        if (st_r.is == I_ADDR || st_r.is == I_WR) begin
          st_nxt.ish = {st_r.ish[6:0], sda};
        end
        if (st_r.is == I_RACK) begin
          st_nxt.hack = ~sda;
        end
      end else if (fall) begin
        // target only, reacting to host clock edges
        case (st_r.is)
          I_ADDR: if (st_r.icnt == 4'h8) begin
            if (st_r.ish[7:1] == `HSI_I2C_ADDR) begin
              st_nxt.is = I_AACK;
              st_nxt.rw = st_r.ish[0];
              st_nxt.sda_low = 1'b1;
            end else begin
              st_nxt.is = I_SKIP;
            end
          end
          I_AACK, I_RACK: begin
            st_nxt.icnt = 4'h0;
            st_nxt.sda_low = 1'b0;
            if (st_r.is == I_AACK && !st_r.rw) begin
              st_nxt.is = I_WR;
            end else if (st_r.is == I_AACK || st_r.hack) begin
              // Every read byte is fetched under a stretch
              st_nxt.is = I_RD;
              st_nxt.scl_hold = 1'b1;
              st_nxt.wait_rd = 1'b1;
            end else begin
              st_nxt.is = I_SKIP;
            end
          end
          I_RD: if (st_r.icnt == 4'h8) begin
            st_nxt.is = I_RACK;
            st_nxt.sda_low = 1'b0;
          end else begin
            st_nxt.ish = {st_r.ish[6:0], 1'b0};
            st_nxt.sda_low = ~st_r.ish[6];
          end
          I_WR: if (st_r.icnt == 4'h8) begin
            st_nxt.is = I_WACK;
            st_nxt.scl_hold = 1'b1;
            st_nxt.wait_wr = 1'b1;
          end
          I_WACK: begin
            st_nxt.is = I_WR;
            st_nxt.icnt = 4'h0;
            st_nxt.sda_low = 1'b0;
          end
          default: ;
        endcase
      end
    end
    push = uart_push | spi_push | i2c_push;
    push_d = i2c_push ? st_r.ish : (spi_push ? lk_r.rx_byte : st_r.rsh);
    // UART and SPI cannot wait, so a full FIFO loses the byte
    st_nxt.drop = (uart_push | spi_push) & ~f_ready;
  end

  always_ff @(posedge I_CLOCK) begin
    if (I_RST) begin
      st_r <= '0;
      st_r.tpin <= 1'b1;
      st_r.div <= `HSI_DIV_DEF;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ==================================================
  // SPI clock domain
  // host drives chip select, which ends the frame state
  assign rst_frame = I_RST | I_SDA;

  always_comb begin
    fr_nxt = fr_r;
    lk_nxt = lk_r;
    lk_nxt.full_s = {lk_r.full_s[0], st_r.spi_full};
    // input sampled on rising edge, next bit out after it
    fr_nxt.cnt = fr_r.cnt + 3'h1;
    fr_nxt.sh = {fr_r.sh[5:0], I_PIN_RX};
    fr_nxt.out = {fr_r.out[6:0], 1'b1};
    if (fr_r.cnt == 3'h7) begin
      lk_nxt.rx_byte = {fr_r.sh, I_PIN_RX};
      lk_nxt.rx_tog = ~lk_r.rx_tog;
      // Byte held stable by the sys side until the take toggle returns
      fr_nxt.out = lk_r.full_s[1] ? st_r.spi_tx : `HSI_SPI_FILL;
      lk_nxt.take_tog = lk_r.take_tog ^ lk_r.full_s[1];
    end
  end

  always_ff @(posedge I_LINK_SCK or posedge rst_frame) begin
    if (rst_frame) begin
      fr_r <= '0;
      fr_r.out <= `HSI_SPI_FILL;
    end else begin
      fr_r <= fr_nxt;
    end
  end

  always_ff @(posedge I_LINK_SCK or posedge I_RST) begin
    if (I_RST) begin
      lk_r <= '0;
    end else begin
      lk_r <= lk_nxt;
    end
  end

  // ==================================================
  // Checks
  logic sda_prev_r;
  logic [4:0] sda_age_r;

  always_ff @(posedge I_CLOCK) begin
    sda_prev_r <= st_r.sda_low;
    if (st_r.sda_low != sda_prev_r) begin
      sda_age_r <= 5'h0;
    end else if (sda_age_r != 5'h1F) begin
      sda_age_r <= sda_age_r + 5'h1;
    end
  end

  sequence s_tx_go;
    st_r.ts == U_IDLE ##1 st_r.ts == U_START;
  endsequence

  property p_div_range;
    @(posedge I_CLOCK) disable iff (I_RST)
    st_r.div >= `HSI_DIV_MIN && st_r.div <= `HSI_DIV_MAX;
  endproperty
  a_div_range: assert property (p_div_range) else $error("divisor out of range");

  property p_tx_start;
    @(posedge I_CLOCK) disable iff (I_RST)
    s_tx_go |-> !O_PIN_TX && st_r.tdiv == st_r.tbaud - 16'h1;
  endproperty
  a_tx_start: assert property (p_tx_start) else $error("start bit wrong");

  property p_tx_hold;
    @(posedge I_CLOCK) disable iff (I_RST)
    (st_r.ts != U_IDLE && st_r.tdiv != 16'h0) |=> $stable(O_PIN_TX);
  endproperty
  a_tx_hold: assert property (p_tx_hold) else $error("tx bit changed early");

  property p_rx_half;
    @(posedge I_CLOCK) disable iff (I_RST)
    (st_r.rs == U_START && $past(st_r.rs) == U_IDLE) |-> st_r.rdiv == ($past(st_r.div) >> 1);
  endproperty
  a_rx_half: assert property (p_rx_half) else $error("rx not centred");

  property p_uart_sel;
    @(posedge I_CLOCK) disable iff (I_RST)
    (st_r.mode_ok && !st_r.spi && st_r.ts == U_IDLE) |-> O_PIN_TX && !O_PIN_TX_OE_N;
  endproperty
  a_uart_sel: assert property (p_uart_sel) else $error("uart idle line wrong");

  property p_spi_hiz;
    @(posedge I_CLOCK) disable iff (I_RST)
    (st_r.spi && I_SDA) |-> O_PIN_TX_OE_N;
  endproperty
  a_spi_hiz: assert property (p_spi_hiz) else $error("data out driven while deselected");

  property p_i2c_off;
    @(posedge I_CLOCK) disable iff (I_RST)
    st_r.spi |-> O_SCL_OE_N && O_SDA_OE_N;
  endproperty
  a_i2c_off: assert property (p_i2c_off) else $error("i2c active in spi mode");

  property p_mode_hold;
    @(posedge I_CLOCK) disable iff (I_RST)
    st_r.mode_ok |=> st_r.mode_ok && $stable(st_r.spi);
  endproperty
  a_mode_hold: assert property (p_mode_hold) else $error("mode changed");

  property p_stretch;
    @(posedge I_CLOCK) disable iff (I_RST)
    st_r.scl_hold |-> st_r.stc <= 23'(STRETCH_MAX);
  endproperty
  a_stretch: assert property (p_stretch) else $error("stretch too long");

  property p_lead;
    @(posedge I_CLOCK) disable iff (I_RST)
    $rose(O_SCL_OE_N) |-> sda_age_r >= 5'(`HSI_SDA_LEAD_CYC - 1);
  endproperty
  a_lead: assert property (p_lead) else $error("sda lead too short");

  property p_def_baud;
    @(posedge I_CLOCK) disable iff (I_RST)
    $past(I_RST) |-> st_r.div == `HSI_DIV_DEF;
  endproperty
  a_def_baud: assert property (p_def_baud) else $error("reset baud wrong");
endmodule

// ### hdl/hsi_map.svh
// Constants of the host serial front end: rates, timing counts, reset values
// Functional notes
// - Configurable UART baud between 9600 and 921600 bit/s on both sides.
// - UART transmit bit timing within one percent of the configured rate.
// - UART receiver accepts characters off-rate by up to 2.5 percent.
// - No RTS/CTS flow control; neither side pauses transmission by hardware.
// - Primary UART enabled when the select strap is high or open.
// - SPI off by default, shares UART/I2C pins, active only with strap low.
// - SPI device is peripheral only; host drives chip select and clock.
// - SPI mode 0: clock idles low, data sampled on rising edge.
// - I2C device is target only; host clock at most 400 kbit/s.
// - Device may stretch SCL low at most 20 ms; host tolerates it.
// - After stretching, SDA leads clock release by at least 62.5 ns.
// - I2C disabled whenever the strap selects SPI.
// - Separate USB full-speed port at 12 Mbit/s, not on strap pins.
// - In SPI mode, data out driven while chip select low, else input.
// - UART resets to 38400 baud, 8 data bits, no parity, 1 stop.
`ifndef HSI_MAP_SVH
`define HSI_MAP_SVH

`define HSI_CLK_HZ 250000000
`define HSI_BAUD_MIN 9600
`define HSI_BAUD_MAX 921600
`define HSI_BAUD_DEF 38400
`define HSI_DIV_DEF 16'((`HSI_CLK_HZ + `HSI_BAUD_DEF / 2) / `HSI_BAUD_DEF)
`define HSI_DIV_MIN 16'((`HSI_CLK_HZ + `HSI_BAUD_MAX - 1) / `HSI_BAUD_MAX)
`define HSI_DIV_MAX 16'(`HSI_CLK_HZ / `HSI_BAUD_MIN)
`define HSI_STRETCH_MAX_US 20000
`define HSI_STRETCH_CYC (`HSI_STRETCH_MAX_US * (`HSI_CLK_HZ / 1000000))
`define HSI_STRETCH_MARGIN 32
`define HSI_SDA_LEAD_PS 62500
`define HSI_SDA_LEAD_CYC 5'((`HSI_SDA_LEAD_PS * (`HSI_CLK_HZ / 1000000) + 999999) / 1000000)
`define HSI_USB_BIT_RATE 12000000
`define HSI_I2C_ADDR 7'h42
`define HSI_SPI_FILL 8'hFF
`define HSI_STRAP_SETTLE 2'h3
`define HSI_FIFO_DEPTH 4
`define HSI_BYTE_W 8

`endif

// ### hdl/hsi_pkg.sv
// Types shared by the host serial front end
package hsi_pkg;

  typedef struct packed {
    logic valid;
    logic [7:0] data;
  } byte_t;

  typedef enum logic [1:0] {U_IDLE, U_START, U_DATA, U_STOP} uart_st_t;

  typedef enum logic [2:0] {
    I_IDLE, I_ADDR, I_AACK, I_WR, I_WACK, I_RD, I_RACK, I_SKIP
  } i2c_st_t;

  typedef struct packed {
    logic [1:0] strap_s;
    logic [1:0] settle;
    logic mode_ok;
    logic spi;
    logic [15:0] div;
    logic [1:0] rxd_s;
    logic [2:0] scl_s;
    logic [2:0] sda_s;
    logic [2:0] rxt_s;
    logic [2:0] take_s;
    uart_st_t ts;
    logic [15:0] tdiv;
    logic [15:0] tbaud;
    logic [2:0] tbit;
    logic [7:0] tsh;
    logic tpin;
    uart_st_t rs;
    logic [15:0] rdiv;
    logic [2:0] rbit;
    logic [7:0] rsh;
    logic spi_full;
    logic [7:0] spi_tx;
    i2c_st_t is;
    logic [3:0] icnt;
    logic [7:0] ish;
    logic rw;
    logic hack;
    logic sda_low;
    logic scl_hold;
    logic wait_rd;
    logic wait_wr;
    logic [22:0] stc;
    logic [4:0] lead;
    logic drop;
    logic ferr;
  } sys_t;

  typedef struct packed {
    logic [2:0] cnt;
    logic [6:0] sh;
    logic [7:0] out;
  } frame_t;

  typedef struct packed {
    logic [7:0] rx_byte;
    logic rx_tog;
    logic take_tog;
    logic [1:0] full_s;
  } link_t;

endpackage

// ### tb/hsi_host.sv
// Host model: UART peer and SPI controller
`timescale 1ns/1ns
module hsi_host (
  input wire logic i_clk,
  input wire logic i_uart_en,
  input wire logic [15:0] i_div,
  input wire logic i_txd,
  output logic o_rxd,
  output logic o_sck,
  output logic o_cs_n,
  output logic o_got,
  output logic [7:0] o_got_data,
  input wire logic i_scl,
  input wire logic i_sda,
  output logic o_scl,
  output logic o_sda
);
  logic [7:0] sh;
  // ==========
  // UART
  // 8N1, never paused
  task automatic uart_send(input logic [7:0] b, input int d, input logic stop);
    logic [9:0] f;
    f = {stop, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      @(posedge i_clk) #1 o_rxd = f[i];
      repeat (d - 1) @(posedge i_clk);
    end
    @(posedge i_clk) #1 o_rxd = 1'b1;
  endtask
  initial begin
    o_rxd = 1'b1;
    o_sck = 1'b0;
    o_cs_n = 1'b1;
    o_got = 1'b0;
    o_got_data = 8'h00;
    o_scl = 1'b1;
    o_sda = 1'b1;
    forever begin
      @(negedge i_txd);
      if (i_uart_en) begin
        repeat (i_div / 2) @(posedge i_clk);
        for (int i = 0; i < 8; i++) begin
          repeat (i_div) @(posedge i_clk);
          sh[i] = i_txd;
        end
        repeat (i_div) @(posedge i_clk);
        // Missing stop bit gives no byte
        #1 o_got_data = sh;
        o_got = i_txd;
        @(posedge i_clk) #1 o_got = 1'b0;
      end
    end
  end
  // ==========
  // SPI
  // mode 0, MSB first, clock still outside bytes
  task automatic spi_xfer(input logic [15:0] mo, output logic [15:0] mi);
    o_cs_n = 1'b0;
    #20;
    for (int i = 15; i >= 0; i--) begin
      o_rxd = mo[i];
      #3 o_sck = 1'b1;
      mi[i] = i_txd;
      #3 o_sck = 1'b0;
      // pause keeps the byte rate low
      if (i == 8) #200;
    end
    #40 o_cs_n = 1'b1;
  endtask
  // ==========
  // I2C controller
  // Fast-mode bit times, data moved only while SCL low
  task automatic i2c_bit(input logic v, output logic r);
    int n;
    #300 o_sda = v;
    #1000 o_scl = 1'b1;
    n = 0;
    // host waits out a stretch, bounded
    while (i_scl !== 1'b1 && n < 4000) begin
      @(posedge i_clk) #1 n++;
    end
    #600 r = i_sda;
    o_scl = 1'b0;
  endtask
  task automatic i2c_byte(input logic [7:0] v, input logic ack, output logic [7:0] r,
                          output logic a);
    for (int i = 7; i >= 0; i--) begin
      i2c_bit(v[i], r[i]);
    end
    i2c_bit(ack, a);
  endtask
  task automatic i2c_start();
    o_sda = 1'b1;
    o_scl = 1'b1;
    #600 o_sda = 1'b0;
    #600 o_scl = 1'b0;
  endtask
  task automatic i2c_stop();
    #300 o_sda = 1'b0;
    #1000 o_scl = 1'b1;
    #600 o_sda = 1'b1;
    #1300;
  endtask
endmodule

// ### tb/tb_top.sv
// Self-checking bench of the host serial front end
`timescale 1ns/1ns
module tb_top;
  import hsi_pkg::*;
  localparam int TMO = 80000;
  logic clk, rst, strap, spi_sel, baud_set, rx_rdy, tx_pin, tx_oe_n, tx_rdy;
  logic scl_oe_n, sda_oe_n, mode_spi, mode_ok, drop, ferr, rxd, sck, cs_n, got;
  logic [15:0] baud_div, div, m, mi;
  logic [7:0] b, b2, got_data;
  logic h_scl, h_sda, scl_pin, sda_pin, ack;
  int k;
  byte_t tx, rx;
  logic [7:0] exp_q[$], tx_q[$];
  int mismatches, n_compared, n_drop, n_ferr;
  // ==========
  // Design and host
  host_serial_interface_select #(.STRETCH_MAX(2000)) host_serial_interface_select_i (
    .I_CLOCK(clk), .I_RST(rst), .I_SEL_STRAP(strap), .I_LINK_SCK(sck),
    .I_PIN_RX(rxd), .O_PIN_TX(tx_pin), .O_PIN_TX_OE_N(tx_oe_n),
    .I_SCL(scl_pin), .O_SCL(), .O_SCL_OE_N(scl_oe_n),
    .I_SDA(sda_pin), .O_SDA(), .O_SDA_OE_N(sda_oe_n),
    .I_BAUD_SET(baud_set), .I_BAUD_DIV(baud_div), .I_TX(tx), .O_TX_READY(tx_rdy),
    .O_RX(rx), .I_RX_READY(rx_rdy), .O_MODE_SPI(mode_spi), .O_MODE_VALID(mode_ok),
    .O_RX_DROP(drop), .O_FRAME_ERR(ferr));
  // Open-drain wires: low if either side pulls
  assign scl_pin = scl_oe_n & (spi_sel ? sck : h_scl);
  assign sda_pin = spi_sel ? cs_n : (sda_oe_n & h_sda);
  // Released pin reads high through its pull-up
  hsi_host hsi_host_i (
    .i_clk(clk), .i_uart_en(!spi_sel && mode_ok), .i_div(div),
    .i_txd(tx_oe_n ? 1'b1 : tx_pin), .o_rxd(rxd), .o_sck(sck), .o_cs_n(cs_n),
    .o_got(got), .o_got_data(got_data), .i_scl(scl_pin), .i_sda(sda_pin),
    .o_scl(h_scl), .o_sda(h_sda));
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // ==========
  // Checking
  task automatic chk(input logic [15:0] got_v, input logic [15:0] exp_v);
    n_compared++;
    if (got_v !== exp_v) begin
      mismatches++;
      $display("FAIL %0t got %h expected %h", $time, got_v, exp_v);
    end
  endtask
  task automatic fail_now();
    mismatches++;
    $display("FAIL %0t unexpected or missing output", $time);
  endtask
  task automatic finish_test();
    $display("mismatches %0d compared %0d", mismatches, n_compared);
    if (mismatches == 0 && n_compared > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic timeout();
    fail_now();
    finish_test();
  endtask
  always @(negedge clk) begin
    n_drop += (drop === 1'b1);
    n_ferr += (ferr === 1'b1);
    if (rx.valid === 1'b1 && rx_rdy === 1'b1) begin
      if (exp_q.size() == 0) fail_now();
      else chk(rx.data, exp_q.pop_front());
    end
    if (got === 1'b1) begin
      if (tx_q.size() == 0) fail_now();
      else chk(got_data, tx_q.pop_front());
    end
    if (spi_sel && mode_ok === 1'b1) chk({tx_oe_n, scl_oe_n, sda_oe_n}, {cs_n, 2'b11});
  end
  // ==========
  // Drivers
  task automatic do_reset(input logic s);
    int n;
    @(posedge clk) #1 rst = 1'b1;
    strap = s;
    repeat (10) @(posedge clk);
    spi_sel = ~s;
    #1 rst = 1'b0;
    chk({tx_pin, tx_oe_n, scl_oe_n, sda_oe_n, mode_ok, rx.valid}, 16'h003C);
    n = 0;
    while (mode_ok !== 1'b1 && n < 9) begin
      @(posedge clk) #1 n++;
    end
    chk(n == 4 || n == 5, 16'h0001);
    chk({mode_spi, tx_oe_n}, {~s, ~s});
  endtask
  task automatic send_tx(input logic [7:0] v);
    int n;
    @(posedge clk) #1 tx = {1'b1, v};
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (tx_rdy !== 1'b1 && n < TMO);
    if (n >= TMO) timeout();
    @(posedge clk) #1 tx.valid = 1'b0;
  endtask
  task automatic wait_done();
    int n;
    n = 0;
    while (exp_q.size() + tx_q.size() > 0 && n < TMO) begin
      @(posedge clk);
      n++;
    end
    if (n >= TMO) timeout();
    #1;
  endtask
  // ==========
  // Scenarios
  initial begin
    rst = 1'b1;
    strap = 1'b1;
    spi_sel = 1'b0;
    baud_set = 1'b0;
    baud_div = 16'h0000;
    tx = '0;
    rx_rdy = 1'b1;
    div = 16'h196E;
    mismatches = 0;
    n_compared = 0;
    n_drop = 0;
    n_ferr = 0;
    void'($urandom(32'h79E1599D));
    do_reset(1'b1);
    b = 8'($urandom());
    tx_q.push_back(b);
    send_tx(b);
    wait_done();
    // Fastest rate, strap moved after capture
    @(posedge clk) #1 baud_set = 1'b1;
    baud_div = 16'h0110;
    @(posedge clk) #1 baud_set = 1'b0;
    div = 16'h0110;
    strap = 1'b0;
    for (int i = 0; i < 2; i++) begin
      b = 8'($urandom());
      tx_q.push_back(b);
      send_tx(b);
    end
    wait_done();
    chk(mode_spi, 16'h0000);
    strap = 1'b1;
    // Fill the buffer while stalled, off-rate senders
    rx_rdy = 1'b0;
    for (int i = 0; i < 5; i++) begin
      b = 8'($urandom());
      if (i < 4) exp_q.push_back(b);
      hsi_host_i.uart_send(b, i[0] ? 16'h0116 : 16'h010A, 1'b1);
    end
    repeat (300) @(posedge clk);
    chk(16'(n_drop), 16'h0001);
    #1 rx_rdy = 1'b1;
    wait_done();
    hsi_host_i.uart_send(8'h5A, 16'h0110, 1'b0);
    repeat (300) @(posedge clk);
    chk(16'(n_ferr), 16'h0001);
    // I2C write into the FIFO, then a read fed under stretch
    b = 8'($urandom());
    exp_q.push_back(b);
    hsi_host_i.i2c_start();
    hsi_host_i.i2c_byte(8'h84, 1'b1, b2, ack);
    chk(ack, 16'h0000);
    hsi_host_i.i2c_byte(b, 1'b1, b2, ack);
    chk(ack, 16'h0000);
    hsi_host_i.i2c_stop();
    wait_done();
    b = 8'($urandom());
    hsi_host_i.i2c_start();
    hsi_host_i.i2c_byte(8'h85, 1'b1, b2, ack);
    chk(ack, 16'h0000);
    fork
      hsi_host_i.i2c_byte(8'hFF, 1'b1, b2, ack);
      begin
        k = 0;
        while (scl_oe_n !== 1'b0 && k < TMO) begin
          @(negedge clk) k++;
        end
        if (k >= TMO) timeout();
        send_tx(b);
      end
    join
    hsi_host_i.i2c_stop();
    chk(b2, b);
    chk(ack, 16'h0001);
    // SPI mode: reply lags one byte
    do_reset(1'b0);
    b = 8'($urandom());
    send_tx(b);
    m = 16'($urandom());
    exp_q.push_back(m[15:8]);
    exp_q.push_back(m[7:0]);
    hsi_host_i.spi_xfer(m, mi);
    chk(mi, {8'hFF, b});
    wait_done();
    finish_test();
  end
endmodule
